/* File: hdl/dgp_top.sv */
// Dual pin port with peripheral sharing, APB register slave
//
// Overview of operation
// - First port direction 1 input, 0 drives
// - Second port direction behaves the same
// - First port eight individually bidirectional pins
// - Second port five pins, low bits only
// - Pins read levels, write updates latch
// - Latch register reads stored latch value
// - After reset analog pins six-zero read zero
// - First direction resets all ones, every reset
// - First latch clears on power-on only
// - Pins one, two carry comparator outputs
// - Pin five drives comparator reference output
// - Pin seven serves as slave select
// - Enabled peripheral overrides pin direction, except CCP capture
// - Override never written into direction register
// - Second port pins reset to inputs
// - Second port pins feed capture/compare units
// - Second port pins carry second USART
// - Second direction all ones, values kept
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps

module dgp_top (
	input  wire logic                                  clk_i,
	input  wire logic                                  reset_i,
	input  wire logic                                  soft_reset_i,
	input  wire logic                                  psel_i,
	input  wire logic                                  penable_i,
	input  wire logic                                  pwrite_i,
	input  wire logic [dgp_pkg::APB_ADDR_WIDTH-1:0]   paddr_i,
	input  wire logic [31:0]                           pwdata_i,
	input  wire logic [3:0]                            pstrb_i,
	output logic      [31:0]                           prdata_o,
	output logic                                       pready_o,
	output logic                                       pslverr_o,
	input  wire logic [dgp_pkg::PORT_F_WIDTH-1:0]     port_f_pin_i,
	output logic      [dgp_pkg::PORT_F_WIDTH-1:0]     port_f_pin_o,
	output logic      [dgp_pkg::PORT_F_WIDTH-1:0]     port_f_pin_oe_o,
	input  wire logic [dgp_pkg::PORT_G_WIDTH-1:0]     port_g_pin_i,
	output logic      [dgp_pkg::PORT_G_WIDTH-1:0]     port_g_pin_o,
	output logic      [dgp_pkg::PORT_G_WIDTH-1:0]     port_g_pin_oe_o,
	input  wire logic                                  comparator_one_output_i,
	input  wire logic                                  comparator_two_output_i,
	output logic                                       comparator_reference_output_o,
	output logic                                       ssp_slave_select_o,
	input  wire logic [2:0]                            ccp_compare_level_i,
	input  wire logic [2:0]                            ccp_drive_i,
	output logic      [2:0]                            ccp_capture_o,
	input  wire logic                                  second_usart_tx_or_clock_i,
	input  wire logic                                  second_usart_data_out_i,
	input  wire logic                                  second_usart_data_drive_i,
	output logic                                       second_usart_rx_or_data_o
);
	localparam int FW = dgp_pkg::PORT_F_WIDTH;
	localparam int GW = dgp_pkg::PORT_G_WIDTH;

	typedef struct packed {
		logic [FW-1:0] f_dir;
		logic [FW-1:0] f_lat;
		logic [GW-1:0] g_dir;
		logic [GW-1:0] g_lat;
		logic [6:0]    ana_dig;
		logic [7:0]    periph;
		logic [FW-1:0] f_s1;
		logic [FW-1:0] f_s2;
		logic [FW-1:0] f_s3;
		logic [FW-1:0] f_lvl;
		logic [GW-1:0] g_s1;
		logic [GW-1:0] g_s2;
		logic [GW-1:0] g_s3;
		logic [GW-1:0] g_lvl;
		logic [FW-1:0] f_out;
		logic [FW-1:0] f_oe;
		logic [GW-1:0] g_out;
		logic [GW-1:0] g_oe;
		logic          comparator_reference_output;
		logic          ss;
		logic [2:0]    capture;
		logic          rx;
		logic          pready;
		logic          pslverr;
		logic [31:0]   prdata;
	} dgp_state_s;

	dgp_state_s st;
	dgp_state_s next_st;

	// A bit only moves once the last two stages agree, so a one-cycle glitch never reaches software
	function automatic logic [7:0] dgp_settle(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] cur);
		dgp_settle = (a & b) | (cur & (a ^ b));
	endfunction

	function automatic logic dgp_mapped(input logic [7:0] adr);
		case (adr)
			dgp_pkg::OFS_F_DIRECTION,
			dgp_pkg::OFS_F_PINS,
			dgp_pkg::OFS_F_LATCH,
			dgp_pkg::OFS_G_PINS,
			dgp_pkg::OFS_G_LATCH,
			dgp_pkg::OFS_G_DIRECTION,
			dgp_pkg::OFS_ANALOG_CONFIG,
			dgp_pkg::OFS_PERIPH_ENABLE: dgp_mapped = 1'b1;
			default: dgp_mapped = 1'b0;
		endcase
	endfunction

	logic [FW-1:0] f_read;
	logic [7:0]    adr;
	logic          access;
	logic          do_write;
	logic          mapped;

	always_comb begin
		next_st = st;
		adr = paddr_i[7:0];
		mapped = dgp_mapped(adr);
		access = psel_i & penable_i;
		do_write = access & st.pready & pwrite_i & pstrb_i[0] & mapped;

		next_st.f_s1 = port_f_pin_i;
		next_st.f_s2 = st.f_s1;
		next_st.f_s3 = st.f_s2;
		next_st.f_lvl = dgp_settle(st.f_s2, st.f_s3, st.f_lvl);
		next_st.g_s1 = port_g_pin_i;
		next_st.g_s2 = st.g_s1;
		next_st.g_s3 = st.g_s2;
		next_st.g_lvl = GW'(dgp_settle({3'h0, st.g_s2}, {3'h0, st.g_s3}, {3'h0, st.g_lvl}));

		// Analog pins read zero until configured digital
		f_read = st.f_lvl & {1'b1, st.ana_dig};

		// One wait state: pready rises in the second access cycle
		next_st.pready = access & ~st.pready;
		if (access & ~st.pready) begin
			next_st.pslverr = ~mapped;
			case (adr)
				dgp_pkg::OFS_F_DIRECTION:   next_st.prdata = {24'h0, st.f_dir};
				dgp_pkg::OFS_F_PINS:        next_st.prdata = {24'h0, f_read};
				dgp_pkg::OFS_F_LATCH:       next_st.prdata = {24'h0, st.f_lat};
				dgp_pkg::OFS_G_PINS:        next_st.prdata = {27'h0, st.g_lvl};
				dgp_pkg::OFS_G_LATCH:       next_st.prdata = {27'h0, st.g_lat};
				dgp_pkg::OFS_G_DIRECTION:   next_st.prdata = {27'h0, st.g_dir};
				dgp_pkg::OFS_ANALOG_CONFIG: next_st.prdata = {25'h0, st.ana_dig};
				dgp_pkg::OFS_PERIPH_ENABLE: next_st.prdata = {24'h0, st.periph};
				default:                    next_st.prdata = 32'h0;
			endcase
		end else begin
			// Answer stands for the ready cycle only, then the bus reads zero again
			next_st.pslverr = 1'b0;
			next_st.prdata = 32'h0;
		end

		if (do_write) begin
			case (adr)
				dgp_pkg::OFS_F_DIRECTION:   next_st.f_dir = pwdata_i[FW-1:0];
				dgp_pkg::OFS_F_PINS:        next_st.f_lat = pwdata_i[FW-1:0];
				dgp_pkg::OFS_F_LATCH:       next_st.f_lat = pwdata_i[FW-1:0];
				dgp_pkg::OFS_G_PINS:        next_st.g_lat = pwdata_i[GW-1:0];
				dgp_pkg::OFS_G_LATCH:       next_st.g_lat = pwdata_i[GW-1:0];
				dgp_pkg::OFS_G_DIRECTION:   next_st.g_dir = pwdata_i[GW-1:0];
				dgp_pkg::OFS_ANALOG_CONFIG: next_st.ana_dig = pwdata_i[6:0];
				dgp_pkg::OFS_PERIPH_ENABLE: next_st.periph = pwdata_i[7:0];
				default:                    next_st.f_dir = st.f_dir;
			endcase
		end

		// Warm reset keeps both latches but returns directions and sharing to default
		if (soft_reset_i) begin
			next_st.f_dir = dgp_pkg::RST_F_DIRECTION;
			next_st.g_dir = dgp_pkg::RST_G_DIRECTION;
			next_st.ana_dig = dgp_pkg::RST_ANALOG_CONFIG;
			next_st.periph = dgp_pkg::RST_PERIPH_ENABLE;
		end

		// Drivers follow direction and latch; overrides never touch the stored bits
		next_st.f_oe = ~st.f_dir;
		next_st.f_out = st.f_lat;
		next_st.g_oe = ~st.g_dir;
		next_st.g_out = st.g_lat;

		if (st.periph[dgp_pkg::PE_CMP2_OUT]) begin
			next_st.f_oe[dgp_pkg::PIN_F_CMP2] = 1'b1;
			next_st.f_out[dgp_pkg::PIN_F_CMP2] = comparator_two_output_i;
		end
		if (st.periph[dgp_pkg::PE_CMP1_OUT]) begin
			next_st.f_oe[dgp_pkg::PIN_F_CMP1] = 1'b1;
			next_st.f_out[dgp_pkg::PIN_F_CMP1] = comparator_one_output_i;
		end
		// The reference is analog, so the digital driver must let go of the pin
		next_st.comparator_reference_output = st.periph[dgp_pkg::PE_COMPARATOR_REFERENCE_OUTPUT_OUT];
		if (st.periph[dgp_pkg::PE_COMPARATOR_REFERENCE_OUTPUT_OUT]) begin
			next_st.f_oe[dgp_pkg::PIN_F_COMPARATOR_REFERENCE_OUTPUT] = 1'b0;
		end
		next_st.ss = st.f_lvl[dgp_pkg::PIN_F_SSP] | ~st.periph[dgp_pkg::PE_SSP_SELECT];
		if (st.periph[dgp_pkg::PE_SSP_SELECT]) begin
			next_st.f_oe[dgp_pkg::PIN_F_SSP] = 1'b0;
		end

		// Capture mode leaves the direction bit in charge; compare and PWM force a drive
		next_st.capture = {st.g_lvl[dgp_pkg::PIN_G_CAPTURE_COMPARE_UNIT_5], st.g_lvl[dgp_pkg::PIN_G_CAPTURE_COMPARE_UNIT_4],
			st.g_lvl[dgp_pkg::PIN_G_CAPTURE_COMPARE_UNIT_3]};
		if (st.periph[dgp_pkg::PE_CAPTURE_COMPARE_UNIT_3] & ccp_drive_i[0]) begin
			next_st.g_oe[dgp_pkg::PIN_G_CAPTURE_COMPARE_UNIT_3] = 1'b1;
			next_st.g_out[dgp_pkg::PIN_G_CAPTURE_COMPARE_UNIT_3] = ccp_compare_level_i[0];
		end
		if (st.periph[dgp_pkg::PE_CAPTURE_COMPARE_UNIT_4] & ccp_drive_i[1]) begin
			next_st.g_oe[dgp_pkg::PIN_G_CAPTURE_COMPARE_UNIT_4] = 1'b1;
			next_st.g_out[dgp_pkg::PIN_G_CAPTURE_COMPARE_UNIT_4] = ccp_compare_level_i[1];
		end
		if (st.periph[dgp_pkg::PE_CAPTURE_COMPARE_UNIT_5] & ccp_drive_i[2]) begin
			next_st.g_oe[dgp_pkg::PIN_G_CAPTURE_COMPARE_UNIT_5] = 1'b1;
			next_st.g_out[dgp_pkg::PIN_G_CAPTURE_COMPARE_UNIT_5] = ccp_compare_level_i[2];
		end

		next_st.rx = st.g_lvl[dgp_pkg::PIN_G_RX_DT];
		if (st.periph[dgp_pkg::PE_USART2]) begin
			next_st.g_oe[dgp_pkg::PIN_G_TX_CK] = 1'b1;
			next_st.g_out[dgp_pkg::PIN_G_TX_CK] = second_usart_tx_or_clock_i;
			next_st.g_oe[dgp_pkg::PIN_G_RX_DT] = second_usart_data_drive_i;
			next_st.g_out[dgp_pkg::PIN_G_RX_DT] = second_usart_data_out_i;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			st <= '0;
			st.f_dir <= dgp_pkg::RST_F_DIRECTION;
			st.f_lat <= dgp_pkg::RST_F_LATCH;
			st.g_dir <= dgp_pkg::RST_G_DIRECTION;
			st.g_lat <= dgp_pkg::RST_G_LATCH;
			st.ana_dig <= dgp_pkg::RST_ANALOG_CONFIG;
			st.periph <= dgp_pkg::RST_PERIPH_ENABLE;
			st.ss <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign prdata_o = st.prdata;
	assign pready_o = st.pready;
	assign pslverr_o = st.pslverr;
	assign port_f_pin_o = st.f_out;
	assign port_f_pin_oe_o = st.f_oe;
	assign port_g_pin_o = st.g_out;
	assign port_g_pin_oe_o = st.g_oe;
	assign comparator_reference_output_o = st.comparator_reference_output;
	assign ssp_slave_select_o = st.ss;
	assign ccp_capture_o = st.capture;
	assign second_usart_rx_or_data_o = st.rx;
endmodule

/* File: hdl/dgp_pkg.sv */
// Constants shared by the dual pin port block
package dgp_pkg;
	localparam int          CLK_PERIOD_NS     = 10;
	localparam int          PORT_F_WIDTH      = 8;
	localparam int          PORT_G_WIDTH      = 5;
	localparam int          ANALOG_PINS       = 7;
	localparam int          PERIPH_BITS       = 8;
	localparam int          SYNC_STAGES       = 3;
	localparam int          APB_ADDR_WIDTH    = 8;

	localparam logic [7:0]  OFS_F_DIRECTION   = 8'h00;
	localparam logic [7:0]  OFS_F_PINS        = 8'h04;
	localparam logic [7:0]  OFS_F_LATCH       = 8'h08;
	localparam logic [7:0]  OFS_G_PINS        = 8'h0C;
	localparam logic [7:0]  OFS_G_LATCH       = 8'h10;
	localparam logic [7:0]  OFS_G_DIRECTION   = 8'h14;
	localparam logic [7:0]  OFS_ANALOG_CONFIG = 8'h18;
	localparam logic [7:0]  OFS_PERIPH_ENABLE = 8'h1C;

	localparam logic [7:0]  RST_F_DIRECTION   = 8'hFF;
	localparam logic [7:0]  RST_F_LATCH       = 8'h00;
	localparam logic [4:0]  RST_G_DIRECTION   = 5'h1F;
	localparam logic [4:0]  RST_G_LATCH       = 5'h00;
	localparam logic [6:0]  RST_ANALOG_CONFIG = 7'h00;
	localparam logic [7:0]  RST_PERIPH_ENABLE = 8'h00;

	// Peripheral enable bit positions
	localparam int          PE_CMP1_OUT       = 0;
	localparam int          PE_CMP2_OUT       = 1;
	localparam int          PE_COMPARATOR_REFERENCE_OUTPUT_OUT      = 2;
	localparam int          PE_SSP_SELECT     = 3;
	localparam int          PE_CAPTURE_COMPARE_UNIT_3           = 4;
	localparam int          PE_CAPTURE_COMPARE_UNIT_4           = 5;
	localparam int          PE_CAPTURE_COMPARE_UNIT_5           = 6;
	localparam int          PE_USART2         = 7;

	// Pin positions of shared functions
	localparam int          PIN_F_CMP2        = 1;
	localparam int          PIN_F_CMP1        = 2;
	localparam int          PIN_F_COMPARATOR_REFERENCE_OUTPUT       = 5;
	localparam int          PIN_F_SSP         = 7;
	localparam int          PIN_G_CAPTURE_COMPARE_UNIT_3        = 0;
	localparam int          PIN_G_TX_CK       = 1;
	localparam int          PIN_G_RX_DT       = 2;
	localparam int          PIN_G_CAPTURE_COMPARE_UNIT_4        = 3;
	localparam int          PIN_G_CAPTURE_COMPARE_UNIT_5        = 4;
endpackage

/* File: verification/dgp_checker.sv */
// Assertions on the ports of the dual pin port block
`timescale 1ns/1ps
module dgp_checker (
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        soft_reset_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0]  pstrb_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic [7:0]  port_f_pin_o,
	input wire logic [7:0]  port_f_pin_oe_o,
	input wire logic [4:0]  port_g_pin_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence s_setup; psel_i && !penable_i; endsequence
	sequence s_wr(logic [7:0] a); pready_o && pwrite_i && pstrb_i[0] && paddr_i == a; endsequence
	a_one_wait: assert property (s_setup ##1 psel_i && penable_i |-> !pready_o ##1 pready_o)
		else $error("ready not in second access cycle");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	a_idle_data: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
		else $error("data or error outside answer");
	a_err_zero: assert property (pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
		else $error("refused read not zero");
	a_g_upper: assert property (pready_o && paddr_i inside {8'h0C, 8'h10, 8'h14} |->
		prdata_o[31:5] == 27'h0) else $error("upper bits of second port not zero");
	// Only pins without a shared function, so overrides cannot mask a slip
	a_dir_oe: assert property (s_wr(8'h00) |-> ##2
		(port_f_pin_oe_o & 8'h59) == (~$past(pwdata_i[7:0], 2) & 8'h59))
		else $error("direction write not on drivers");
	a_latch_out: assert property (s_wr(8'h04) or s_wr(8'h08) |-> ##2
		(port_f_pin_o & 8'h59) == ($past(pwdata_i[7:0], 2) & 8'h59))
		else $error("latch write not on pins");
	a_reset_in: assert property ($fell(reset_i) |->
		{port_f_pin_oe_o, port_g_pin_oe_o} == 13'h0)
		else $error("pins not inputs after reset");
	a_soft_in: assert property (soft_reset_i |-> ##2
		{port_f_pin_oe_o, port_g_pin_oe_o} == 13'h0)
		else $error("pins not inputs after soft reset");
endmodule

/* File: verification/dgp_board.sv */
// Board circuitry on one pin port: pull-ups and external drivers
`timescale 1ns/1ps
module dgp_board #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] drv_i,
	input  wire logic [W-1:0] oe_i,
	input  wire logic [W-1:0] ext_i,
	input  wire logic [W-1:0] ext_en_i,
	output logic      [W-1:0] pin_o
);
	// Pull-ups hold released pins high, so a stale level is never read back
	assign pin_o = (oe_i & drv_i) | (~oe_i & ((ext_en_i & ext_i) | ~ext_en_i));
endmodule

/* File: verification/tb_dgp_top.sv */
// Self-checking bench for the dual pin port block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("Error %0t got %0h exp %0h", $time, a, b); end end
module tb_dgp_top;
	logic        clk_i = 0, reset_i = 1, soft_reset_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [7:0]  paddr_i = '0, port_f_pin_i, port_f_pin_o, port_f_pin_oe_o, f_ext = 8'h4F, f_en = '0;
	logic [31:0] pwdata_i = '0, prdata_o, rd;
	logic [3:0]  pstrb_i = 4'hF;
	logic [4:0]  port_g_pin_i, port_g_pin_o, port_g_pin_oe_o, g_en = '0;
	logic [2:0]  ccp_compare_level_i = '0, ccp_drive_i = '0, ccp_capture_o;
	logic        pready_o, pslverr_o, er, comparator_one_output_i = 0, comparator_two_output_i = 0;
	logic        comparator_reference_output_o, ssp_slave_select_o, second_usart_tx_or_clock_i = 0;
	logic        second_usart_data_out_i = 0, second_usart_data_drive_i = 0, second_usart_rx_or_data_o;
	int          n_fail = 0, total_checks = 0;
	dgp_top dgp_top_i (.clk_i, .reset_i, .soft_reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .port_f_pin_i, .port_f_pin_o,
		.port_f_pin_oe_o, .port_g_pin_i, .port_g_pin_o, .port_g_pin_oe_o, .comparator_one_output_i,
		.comparator_two_output_i, .comparator_reference_output_o, .ssp_slave_select_o,
		.ccp_compare_level_i, .ccp_drive_i, .ccp_capture_o, .second_usart_tx_or_clock_i,
		.second_usart_data_out_i, .second_usart_data_drive_i, .second_usart_rx_or_data_o);
	dgp_board #(.W(8)) dgp_board_i (.drv_i(port_f_pin_o), .oe_i(port_f_pin_oe_o), .ext_i(f_ext),
		.ext_en_i(f_en), .pin_o(port_f_pin_i));
	dgp_board #(.W(5)) dgp_board_g_i (.drv_i(port_g_pin_o), .oe_i(port_g_pin_oe_o), .ext_i(5'h00),
		.ext_en_i(g_en), .pin_o(port_g_pin_i));
	always #5 clk_i = ~clk_i;
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 50);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (n >= 50) begin n_fail++; finish_test(); end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask
	task automatic t_reset();
		`CHK({port_f_pin_oe_o, port_g_pin_oe_o}, 13'h0)
		rdchk(8'h00, 32'hFF);
		rdchk(8'h04, 32'h80);
		rdchk(8'h08, 32'h0);
		rdchk(8'h14, 32'h1F);
		rdchk(8'h0C, 32'h1F);
		apb(1'b0, 8'h20, 32'h0);
		`CHK({er, rd}, 33'h100000000)
		$display("reset test done");
	endtask
	task automatic t_port_f();
		apb(1'b1, 8'h18, 32'h7F);
		apb(1'b1, 8'h00, 32'hCF);
		apb(1'b1, 8'h08, 32'hA5);
		f_en <= 8'hFF;
		repeat (6) @(posedge clk_i);
		`CHK({port_f_pin_oe_o, port_f_pin_o}, 16'h30A5)
		rdchk(8'h04, 32'h6F);
		rdchk(8'h08, 32'hA5);
		apb(1'b1, 8'h04, 32'h5A);
		rdchk(8'h08, 32'h5A);
		// A write without the low strobe must leave the latch alone
		pstrb_i <= 4'h0;
		apb(1'b1, 8'h08, 32'h00);
		pstrb_i <= 4'hF;
		rdchk(8'h08, 32'h5A);
		$display("first port test done");
	endtask
	task automatic t_port_g();
		apb(1'b1, 8'h14, 32'hFFFFFFE4);
		apb(1'b1, 8'h10, 32'hFFFFFFFF);
		g_en <= 5'h1F;
		repeat (6) @(posedge clk_i);
		`CHK({port_g_pin_oe_o, port_g_pin_o}, 10'h37F)
		rdchk(8'h14, 32'h04);
		rdchk(8'h10, 32'h1F);
		rdchk(8'h0C, 32'h1B);
		$display("second port test done");
	endtask
	task automatic t_override();
		comparator_one_output_i <= 1'b1;
		ccp_drive_i <= 3'b111;
		ccp_compare_level_i <= 3'b101;
		second_usart_tx_or_clock_i <= 1'b1;
		second_usart_data_drive_i <= 1'b1;
		apb(1'b1, 8'h1C, 32'hFF);
		repeat (8) @(posedge clk_i);
		`CHK({port_f_pin_oe_o, port_f_pin_o[2:1]}, 10'h05A)
		`CHK({comparator_reference_output_o, ssp_slave_select_o}, 2'b10)
		`CHK({port_g_pin_oe_o, port_g_pin_o}, 10'h3F3)
		`CHK({ccp_capture_o, second_usart_rx_or_data_o}, 4'hA)
		rdchk(8'h00, 32'hCF);
		rdchk(8'h14, 32'h04);
		$display("override test done");
	endtask
	task automatic t_soft();
		soft_reset_i <= 1'b1;
		@(posedge clk_i);
		soft_reset_i <= 1'b0;
		rdchk(8'h00, 32'hFF);
		rdchk(8'h08, 32'h5A);
		rdchk(8'h14, 32'h1F);
		rdchk(8'h10, 32'h1F);
		rdchk(8'h1C, 32'h0);
		$display("soft reset test done");
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		t_reset();
		t_port_f();
		t_port_g();
		t_override();
		t_soft();
		finish_test();
	end
endmodule
bind dgp_top dgp_checker dgp_checker_i (.clk_i, .reset_i, .soft_reset_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .port_f_pin_o,
	.port_f_pin_oe_o, .port_g_pin_oe_o);
